// >>> src/afe_clock_control.sv
`timescale 1ns/10ps
// Behaviour
// - Converter clock is root clock divided by a 4-bit field, 1 or 2.
// - Converter divider is fed by the oscillator chosen in the converter source field.
// - System clock is root divided by a 6-bit field, range 1 to 32.
// - System divider values above 32 saturate to divide by 32.
// - System divider value zero behaves as divide by one.
// - Two-bit converter source field picks fast, crystal, slow or external.
// - Two-bit system source field uses the same four-way encoding.
// - Bit 2 gates off the chop clock; resets to one, clock off.
// - Bit 1 stops the wake timer clock; resets to zero.
// - Bit 5 gates the frontend control clock; one stops it.
// - Oscillator control stays locked until the right key value is written to the key register.
// - Any write to a register other than the key or oscillator control relocks protection.
// - Out of reset the system clock runs from the fast oscillator.
module afe_clock_control
    import afe_clock_pkg::*;
(
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    input wire osc_in_t osc_in, // Raw oscillator clocks
    output logic system_clock, // Divided system clock
    output logic converter_clock, // Divided converter clock
    output logic chop_clock, // Gated chop clock
    output logic wake_timer_clock, // Gated wake timer clock
    output logic frontend_control_clock, // Gated frontend control clock
    output logic [15:0] oscillator_control // Oscillator control bits
);

    // ----------
    // Registers and bus phase state
    // ----------
    logic [15:0] clock_divider_config;
    logic [15:0] clock_gate_enable;
    logic [15:0] clock_source_select;
    logic [15:0] oscillator_unlock_key;
    logic [15:0] chop_and_timer_clock_gate;
    logic unlocked;
    logic wr_pending;
    logic [11:0] wr_addr;
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [5:0] sys_div_eff;
    logic [5:0] conv_div_eff;
    logic sys_div_clk;
    logic conv_div_clk;
    clock_ctrl_t ctrl;
    logic [15:0] wdata;
    logic req;

    // Clamp the system divisor to 1..32
    function automatic logic [5:0] clamp_sys(input logic [5:0] v);
        if (v == 6'h00) begin
            clamp_sys = 6'h01;
        end else if (v > sys_div_max) begin
            clamp_sys = sys_div_max;
        end else begin
            clamp_sys = v;
        end
    endfunction

    // Restrict the converter divisor to 1 or 2
    function automatic logic [5:0] clamp_conv(input logic [3:0] v);
        if (v >= conv_div_max) begin
            clamp_conv = {2'h0, conv_div_max};
        end else begin
            clamp_conv = 6'h01;
        end
    endfunction

    // Read mux by address
    function automatic logic [15:0] read_reg(input logic [11:0] a, input logic [15:0] d0,
                                             input logic [15:0] d1, input logic [15:0] d2,
                                             input logic [15:0] d3, input logic [15:0] d4,
                                             input logic [15:0] d5);
        if (a == addr_clock_divider_config) begin
            read_reg = d0;
        end else if (a == addr_clock_gate_enable) begin
            read_reg = d1;
        end else if (a == addr_clock_source_select) begin
            read_reg = d2;
        end else if (a == addr_oscillator_unlock_key) begin
            read_reg = d3;
        end else if (a == addr_chop_and_timer_clock_gate) begin
            read_reg = d4;
        end else if (a == addr_oscillator_control) begin
            read_reg = d5;
        end else begin
            read_reg = 16'h0000;
        end
    endfunction

    // ----------
    // Bus slave
    // ----------
    assign req = hsel && hready && htrans[1];
    assign wdata = hwdata[15:0];

    // Capture write address phase; upper address bits ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_addr <= 12'h000;
        end else if (clk_en) begin
            wr_pending <= req && hwrite;
            if (req) begin
                wr_addr <= haddr[11:0];
            end
        end
    end

    // Zero wait states, OKAY response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data registered in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && req && !hwrite) begin
            hrdata <= {16'h0000, read_reg(haddr[11:0], clock_divider_config, clock_gate_enable,
                                          clock_source_select, oscillator_unlock_key,
                                          chop_and_timer_clock_gate, oscillator_control)};
        end
    end

    // Divider and source registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_divider_config <= rst_clock_divider_config;
            clock_source_select <= rst_clock_source_select; // Fast oscillator
        end else if (clk_en && wr_pending) begin
            if (wr_addr == addr_clock_divider_config) begin
                clock_divider_config <= wdata & mask_clock_divider_config;
            end else if (wr_addr == addr_clock_source_select) begin
                clock_source_select <= wdata & mask_clock_source_select;
            end
        end
    end

    // Gate registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chop_and_timer_clock_gate <= rst_chop_and_timer_clock_gate;
            clock_gate_enable <= rst_clock_gate_enable;
        end else if (clk_en && wr_pending) begin
            if (wr_addr == addr_chop_and_timer_clock_gate) begin
                chop_and_timer_clock_gate <= wdata & mask_chop_and_timer_clock_gate;
            end else if (wr_addr == addr_clock_gate_enable) begin
                clock_gate_enable <= wdata & mask_clock_gate_enable;
            end
        end
    end

    // Key register and lock state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oscillator_unlock_key <= rst_oscillator_unlock_key;
            unlocked <= 1'b0;
        end else if (clk_en && wr_pending) begin
            if (wr_addr == addr_oscillator_unlock_key) begin
                oscillator_unlock_key <= wdata;
                unlocked <= (wdata == unlock_key_value);
            end else if (wr_addr == addr_oscillator_control) begin
                unlocked <= unlocked;
            end else begin
                unlocked <= 1'b0;
            end
        end
    end

    // Oscillator control written only while unlocked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oscillator_control <= rst_oscillator_control;
        end else if (clk_en && wr_pending && wr_addr == addr_oscillator_control && unlocked) begin
            oscillator_control <= wdata & mask_oscillator_control;
        end
    end

    // ----------
    // Clock generation
    // ----------
    // Two-stage synchroniser for oscillator pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else if (clk_en) begin
            sync_a <= {osc_in.external_clock, osc_in.slow_internal_oscillator,
                       osc_in.crystal, osc_in.fast_internal_oscillator};
            sync_b <= sync_a;
        end
    end

    assign ctrl.system_clock_source = clock_source_t'(clock_source_select[sys_src_lsb +: src_w]);
    assign ctrl.converter_clock_source = clock_source_t'(clock_source_select[conv_src_lsb +: src_w]);
    assign ctrl.system_clock_divider = clock_divider_config[sys_div_lsb +: sys_div_w];
    assign ctrl.converter_clock_divider = clock_divider_config[conv_div_lsb +: conv_div_w];
    assign ctrl.chop_clock_off = chop_and_timer_clock_gate[chop_off_bit];
    assign ctrl.wake_timer_clock_off = chop_and_timer_clock_gate[wake_off_bit];
    assign ctrl.frontend_control_clock_off = clock_gate_enable[frontend_off_bit];
    assign sys_div_eff = clamp_sys(ctrl.system_clock_divider);
    assign conv_div_eff = clamp_conv(ctrl.converter_clock_divider);

    // System clock path
    afe_clock_divider u_sys_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .src_sync(sync_b),
        .source(ctrl.system_clock_source),
        .divisor(sys_div_eff),
        .clk_out(sys_div_clk)
    );

    // Converter clock path from the root clock
    afe_clock_divider u_conv_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .src_sync(sync_b),
        .source(ctrl.converter_clock_source),
        .divisor(conv_div_eff),
        .clk_out(conv_div_clk)
    );

    // Output stage: registered clocks and gates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            system_clock <= 1'b0;
            converter_clock <= 1'b0;
            chop_clock <= 1'b0;
            wake_timer_clock <= 1'b0;
            frontend_control_clock <= 1'b0;
        end else if (clk_en) begin
            system_clock <= sys_div_clk;
            converter_clock <= conv_div_clk;
            chop_clock <= sys_div_clk & ~ctrl.chop_clock_off;
            wake_timer_clock <= sync_b[2] & ~ctrl.wake_timer_clock_off;
            frontend_control_clock <= sys_div_clk & ~ctrl.frontend_control_clock_off;
        end
    end

endmodule

// >>> src/afe_clock_pkg.sv
package afe_clock_pkg;

    // ----------
    // Register byte addresses
    // ----------
    localparam logic [11:0] addr_clock_divider_config = 12'h408;
    localparam logic [11:0] addr_clock_gate_enable = 12'h410;
    localparam logic [11:0] addr_clock_source_select = 12'h414;
    localparam logic [11:0] addr_oscillator_unlock_key = 12'ha0c;
    localparam logic [11:0] addr_oscillator_control = 12'ha10;
    localparam logic [11:0] addr_chop_and_timer_clock_gate = 12'ha70;

    // ----------
    // Reset values
    // ----------
    localparam logic [15:0] rst_clock_divider_config = 16'h0441;
    localparam logic [15:0] rst_clock_gate_enable = 16'h01c0;
    localparam logic [15:0] rst_clock_source_select = 16'h0000;
    localparam logic [15:0] rst_oscillator_unlock_key = 16'h0000;
    localparam logic [15:0] rst_chop_and_timer_clock_gate = 16'h0004;
    localparam logic [15:0] rst_oscillator_control = 16'h0003;

    // ----------
    // Field positions, widths, masks and key
    // ----------
    localparam int sys_div_lsb = 0;
    localparam int sys_div_w = 6;
    localparam int conv_div_lsb = 6;
    localparam int conv_div_w = 4;
    localparam int sys_src_lsb = 0;
    localparam int conv_src_lsb = 2;
    localparam int src_w = 2;
    localparam int wake_off_bit = 1;
    localparam int chop_off_bit = 2;
    localparam int frontend_off_bit = 5;
    localparam logic [15:0] mask_clock_divider_config = 16'hffff;
    localparam logic [15:0] mask_clock_source_select = 16'h000f;
    localparam logic [15:0] mask_chop_and_timer_clock_gate = 16'h0007;
    localparam logic [15:0] mask_clock_gate_enable = 16'h03ff;
    localparam logic [15:0] mask_oscillator_control = 16'h0007;
    localparam logic [15:0] unlock_key_value = 16'hcb14;

    // ----------
    // Divider limits and timing
    // ----------
    localparam logic [5:0] sys_div_max = 6'h20;
    localparam logic [3:0] conv_div_max = 4'h2;
    localparam int root_clock_mhz = 16;
    localparam int sys_clock_limit_mhz = 16;
    localparam int hclk_mhz = 125;

    // Clock source encodings
    typedef enum logic [1:0] {
        src_fast_osc = 2'h0,
        src_crystal = 2'h1,
        src_slow_osc = 2'h2,
        src_external = 2'h3
    } clock_source_t;

    // Clock control bundle from the register file
    typedef struct packed {
        clock_source_t system_clock_source;
        clock_source_t converter_clock_source;
        logic [5:0] system_clock_divider;
        logic [3:0] converter_clock_divider;
        logic chop_clock_off;
        logic wake_timer_clock_off;
        logic frontend_control_clock_off;
    } clock_ctrl_t;

    // Raw oscillator clocks sampled as pins
    typedef struct packed {
        logic fast_internal_oscillator;
        logic crystal;
        logic slow_internal_oscillator;
        logic external_clock;
    } osc_in_t;

endpackage

// >>> src/afe_clock_divider.sv
`timescale 1ns/10ps
// Glitch-free source select and divide of one clock, oversampled by hclk
module afe_clock_divider
    import afe_clock_pkg::*;
(
    input wire logic hclk, // Fabric clock
    input wire logic hresetn, // Async reset, active low
    input wire logic clk_en, // Freezes state when low
    input wire logic [3:0] src_sync, // Synchronised source levels
    input wire clock_source_t source, // Chosen source
    input wire logic [5:0] divisor, // Effective divisor, 1 or more
    output logic clk_out // Divided clock
);

    // ----------
    // Source tracking and edge detect
    // ----------
    clock_source_t active_source;
    logic [5:0] active_divisor;
    logic src_prev;
    logic [5:0] edge_count;
    logic src_now;
    logic rise;

    assign src_now = src_sync[active_source];
    assign rise = src_now & ~src_prev;

    // Previous source level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_prev <= 1'b0;
        end else if (clk_en) begin
            src_prev <= src_now;
        end
    end

    // Switch source and divisor only at a period end with output low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_source <= src_fast_osc;
            active_divisor <= 6'h01;
        end else if (clk_en && !clk_out && edge_count == 6'h00 && !src_now) begin
            active_source <= source;
            active_divisor <= divisor;
        end
    end

    // Count source rising edges; toggle output each half period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_count <= 6'h00;
            clk_out <= 1'b0;
        end else if (clk_en) begin
            if (active_divisor == 6'h01) begin
                clk_out <= src_now; // Undivided pass-through
                edge_count <= 6'h00;
            end else if (rise) begin
                if (edge_count == active_divisor - 6'h01) begin
                    edge_count <= 6'h00;
                    clk_out <= 1'b0;
                end else begin
                    edge_count <= edge_count + 6'h01;
                    if (edge_count + 6'h01 == {1'b0, active_divisor[5:1]}) begin
                        clk_out <= 1'b1;
                    end
                end
            end
        end
    end

endmodule

// >>> verification/afe_clock_control_sva.sv
`timescale 1ns/10ps
// ----------
// Bus and clock gating checker
// ----------
module afe_clock_control_chk
    import afe_clock_pkg::*;
(
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Reset, active low
    input wire logic clk_en, // State enable
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write flag
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic chop_clock, // Chop clock
    input wire logic wake_timer_clock, // Wake timer clock
    input wire logic frontend_control_clock, // Frontend clock
    input wire logic [15:0] oscillator_control // Oscillator control bits
);
    logic dp_valid, dp_write, unlocked, chop_off, wake_off, front_off, dp_wr, osc_ok, mapped;
    logic [11:0] dp_addr;
    logic [9:0] quiet;

    // Data phase decode
    assign dp_wr = dp_valid & dp_write & clk_en;
    assign osc_ok = dp_wr & (dp_addr == addr_oscillator_control) & unlocked;
    assign mapped = dp_addr inside {addr_clock_divider_config, addr_clock_gate_enable, addr_clock_source_select,
                                    addr_oscillator_unlock_key, addr_oscillator_control, addr_chop_and_timer_clock_gate};

    // Address phase capture, frozen like the design when clk_en is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
        end else if (clk_en) begin
            dp_valid <= hsel & hready & htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[11:0];
        end
    end

    // Key state: right key opens, a write anywhere but the key or oscillator control closes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlocked <= 1'b0;
        end else if (dp_wr && dp_addr == addr_oscillator_unlock_key) begin
            unlocked <= (hwdata[15:0] == unlock_key_value);
        end else if (dp_wr && dp_addr != addr_oscillator_control) begin
            unlocked <= 1'b0;
        end
    end

    // Shadow of the gate bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chop_off <= 1'b1;
            wake_off <= 1'b0;
            front_off <= 1'b0;
        end else if (dp_wr && dp_addr == addr_chop_and_timer_clock_gate) begin
            chop_off <= hwdata[chop_off_bit];
            wake_off <= hwdata[wake_off_bit];
        end else if (dp_wr && dp_addr == addr_clock_gate_enable) begin
            front_off <= hwdata[frontend_off_bit];
        end
    end

    // Cycles since the last write, saturating; gives gated clocks time to park
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet <= 10'h000;
        end else if (dp_wr) begin
            quiet <= 10'h000;
        end else if (quiet != 10'h3ff) begin
            quiet <= quiet + 10'h001;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_resp_always_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_ready_zero_wait: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    chk_read_upper_zero: assert property (dp_valid && !dp_write |-> hrdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    chk_unmapped_read_zero: assert property (dp_valid && !dp_write && !mapped |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_osc_stays_locked: assert property (!$stable(oscillator_control) |-> $past(osc_ok))
        else $error("oscillator control changed while locked");
    chk_osc_write_lands: assert property (osc_ok |=> oscillator_control == {13'h0000, $past(hwdata[2:0])})
        else $error("unlocked oscillator write lost");
    chk_chop_parked_off: assert property (chop_off && quiet == 10'h3ff |-> !chop_clock)
        else $error("chop clock runs while disabled");
    chk_wake_parked_off: assert property (wake_off && quiet == 10'h3ff |-> !wake_timer_clock)
        else $error("wake timer clock runs while disabled");
    chk_front_parked_off: assert property (front_off && quiet == 10'h3ff |-> !frontend_control_clock)
        else $error("frontend clock runs while disabled");

    cov_osc_unlocked_write: cover property (osc_ok);
    cov_unmapped_read: cover property (dp_valid && !dp_write && !mapped);
    cov_chop_running: cover property (!chop_off && chop_clock);
endmodule

bind afe_clock_control afe_clock_control_chk u_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chop_clock(chop_clock), .wake_timer_clock(wake_timer_clock),
    .frontend_control_clock(frontend_control_clock), .oscillator_control(oscillator_control));

// >>> verification/test_afe_clock_control.sv
`timescale 1ns/10ps
module test_afe_clock_control;
    import afe_clock_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp;
    logic system_clock, converter_clock, chop_clock, wake_timer_clock, frontend_control_clock;
    logic [31:0] hrdata, rdv;
    logic [15:0] oscillator_control;
    osc_in_t osc_in;
    logic [3:0] osc_bits = 4'h0;
    int oc[4] = '{0, 0, 0, 0};
    int half[4] = '{4, 5, 6, 3};
    int t_sd[5] = '{0, 1, 3, 40, 32};
    int t_cd[5] = '{1, 2, 0, 15, 1};
    int t_ss[5] = '{0, 1, 2, 3, 0};
    int t_cs[5] = '{0, 1, 2, 3, 3};
    logic [11:0] ra[5] = '{addr_clock_divider_config, addr_clock_gate_enable, addr_clock_source_select,
                           addr_oscillator_unlock_key, addr_chop_and_timer_clock_gate};
    logic [15:0] rv[5] = '{rst_clock_divider_config, rst_clock_gate_enable, rst_clock_source_select,
                           rst_oscillator_unlock_key, rst_chop_and_timer_clock_gate};
    int err_total = 0;
    int cmp_count = 0;
    int p, ones;

    // Single slave: its ready is the bus ready; struct is fast first
    assign hready = hreadyout;
    assign osc_in = {osc_bits[0], osc_bits[1], osc_bits[2], osc_bits[3]};

    // Bus clock, 8 ns
    initial begin
        forever #4 hclk = ~hclk;
    end

    // Source clocks indexed by source code, half period in bus cycles
    always @(posedge hclk) begin
        for (int i = 0; i < 4; i++) begin
            if (oc[i] == half[i] - 1) begin
                oc[i] <= 0;
                osc_bits[i] <= ~osc_bits[i];
            end else begin
                oc[i] <= oc[i] + 1;
            end
        end
    end

    afe_clock_control u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .osc_in(osc_in), .system_clock(system_clock),
        .converter_clock(converter_clock), .chop_clock(chop_clock), .wake_timer_clock(wake_timer_clock),
        .frontend_control_clock(frontend_control_clock), .oscillator_control(oscillator_control));

    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One single AHB-Lite transfer, address phase then data phase
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(rdv, exp);
    endtask

    // Period in bus cycles between the last two of four rising edges
    task meas(input int which);
        int rises, n, last;
        logic prev, cur;
        rises = 0;
        n = 0;
        last = 0;
        prev = 1'b1;
        p = 0;
        while (rises < 4 && n < 3000) begin
            @(posedge hclk);
            n++;
            case (which)
                0: cur = system_clock;
                1: cur = converter_clock;
                2: cur = chop_clock;
                3: cur = wake_timer_clock;
                default: cur = frontend_control_clock;
            endcase
            if (cur === 1'b1 && prev === 1'b0) begin
                rises++;
                p = n - last;
                last = n;
            end
            prev = cur;
        end
        if (rises < 4) p = 0;
    endtask

    task do_reset;
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    function automatic int eff(input int d);
        return (d == 0) ? 1 : ((d > 32) ? 32 : d);
    endfunction

    task tally_and_finish;
        $display("mismatches %0d of %0d compares", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        do_reset;
        meas(0);
        check(32'(p), 32'(2 * half[0]));
        meas(1);
        check(32'(p), 32'(2 * half[0]));
        for (int i = 0; i < 5; i++) rdchk(ra[i], {16'h0000, rv[i]});
        check({16'h0000, oscillator_control}, {16'h0000, rst_oscillator_control});
        wr(12'h400, 32'h0000_1234);
        rdchk(12'h400, 32'h0);
        wr(addr_clock_source_select, 32'h0000_ffff);
        rdchk(addr_clock_source_select, 32'h0000_000f);
        // Divider and source table, upper divider bits kept at their reset value
        for (int i = 0; i < 5; i++) begin
            wr(addr_clock_divider_config, 32'(1024 + t_cd[i] * 64 + t_sd[i]));
            wr(addr_clock_source_select, 32'(t_cs[i] * 4 + t_ss[i]));
            rdchk(addr_clock_divider_config, 32'(1024 + t_cd[i] * 64 + t_sd[i]));
            meas(0);
            check(32'(p), 32'(2 * half[t_ss[i]] * eff(t_sd[i])));
            meas(1);
            check(32'(p), 32'(2 * half[t_cs[i]] * (t_cd[i] > 1 ? 2 : 1)));
        end
        // Gates on, then all off and held
        wr(addr_chop_and_timer_clock_gate, 32'h0);
        meas(2);
        check(32'(p), 32'(2 * half[0] * 32));
        meas(3);
        check(32'(p), 32'(2 * half[2]));
        meas(4);
        check(32'(p), 32'(2 * half[0] * 32));
        wr(addr_chop_and_timer_clock_gate, 32'h0000_0006);
        wr(addr_clock_gate_enable, 32'h0000_01e0);
        repeat (1100) @(posedge hclk);
        ones = 0;
        repeat (200) begin
            @(posedge hclk);
            ones += int'(chop_clock) + int'(wake_timer_clock) + int'(frontend_control_clock);
        end
        check(32'(ones), 32'h0);
        // Oscillator control key protection
        wr(addr_oscillator_control, 32'h0);
        @(posedge hclk);
        check({16'h0000, oscillator_control}, 32'h0000_0003);
        wr(addr_oscillator_unlock_key, {16'h0000, unlock_key_value});
        rdchk(addr_oscillator_unlock_key, {16'h0000, unlock_key_value});
        wr(addr_oscillator_control, 32'h0000_0005);
        @(posedge hclk);
        check({16'h0000, oscillator_control}, 32'h0000_0005);
        wr(addr_oscillator_unlock_key, {16'h0000, unlock_key_value});
        wr(addr_clock_divider_config, {16'h0000, rst_clock_divider_config});
        wr(addr_oscillator_control, 32'h0000_0002);
        rdchk(addr_oscillator_control, 32'h0000_0005);
        // Frozen state ignores a transfer
        clk_en <= 1'b0;
        wr(addr_chop_and_timer_clock_gate, 32'h0);
        clk_en <= 1'b1;
        rdchk(addr_chop_and_timer_clock_gate, 32'h0000_0006);
        // Second reset in mid-run
        do_reset;
        rdchk(addr_chop_and_timer_clock_gate, {16'h0000, rst_chop_and_timer_clock_gate});
        check({16'h0000, oscillator_control}, {16'h0000, rst_oscillator_control});
        tally_and_finish;
    end

    // Watchdog, well beyond the expected run of some 6000 cycles
    initial begin
        repeat (60000) @(posedge hclk);
        err_total++;
        tally_and_finish;
    end
endmodule
